// file: design/ilf_regs.svh
// register codes, field positions and reset values of the input-limit block
`ifndef ILF_REGS_SVH
`define ILF_REGS_SVH
`define ILF_CODE_HIGH_WARN 8'h57
`define ILF_CODE_LOW_WARN 8'h58
`define ILF_CODE_LOW_FAULT 8'h59
`define ILF_CODE_FAULT_ACTION 8'h5a
`define ILF_RST_HIGH_WARN 16'h0000
`define ILF_RST_LOW_WARN 16'h0000
`define ILF_RST_LOW_FAULT 16'h0000
`define ILF_RST_FAULT_ACTION 8'h00
`define ILF_RESP_MSB 7
`define ILF_RESP_LSB 6
`define ILF_RETRY_MSB 5
`define ILF_RETRY_LSB 3
`define ILF_DELAY_MSB 2
`define ILF_DELAY_LSB 0
`define ILF_RETRY_NONE 3'h0
`define ILF_RETRY_FOREVER 3'h7
`endif

// file: design/ilf_pkg.sv
// types shared by the input-limit fault response block
package ilf_pkg;
  typedef enum logic [1:0] {
    RESP_IGNORE = 2'h0,
    RESP_DELAY_RETRY = 2'h1,
    RESP_DISABLE_RETRY = 2'h2,
    RESP_DISABLE_RESUME = 2'h3
  } ilf_resp_t;

  typedef struct packed {
    ilf_resp_t resp;
    logic [2:0] retries;
    logic [2:0] delayCode;
  } ilf_action_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] code;
    logic [15:0] data;
  } ilf_cmd_t;

  typedef struct packed {
    logic highWarn;
    logic lowWarn;
    logic lowFault;
    logic latchedOff;
  } ilf_status_t;

  // gray along run -> delay -> retry -> latch
  typedef enum logic [2:0] {
    ST_RUN = 3'h0,
    ST_DELAY = 3'h1,
    ST_RETRY = 3'h3,
    ST_LATCH = 3'h2,
    ST_HOLD = 3'h6
  } ilf_state_t;
endpackage

// file: design/ilf_delay_timer.sv
// delay timer: 2**code time units, unit length given in core clock cycles
`timescale 1ns/100ps
module ilf_delay_timer (
  input wire logic core_clk, // device clock
  input wire logic rst_b, // async reset, active low
  input wire logic start, // restart the timer
  input wire logic stop, // abandon a running delay
  input wire logic [2:0] delayCode, // exponent of the unit count
  input wire logic [15:0] unitCycles, // clock cycles per time unit
  output logic done // one-cycle pulse at expiry
);
  logic [15:0] divCnt_q;
  logic [7:0] unitsLeft_q;
  logic running_q;
  logic unitTick;
  logic [15:0] divLast;

  // a zero unit length would wrap to 65536 cycles, so treat it as one cycle
  assign divLast = (unitCycles == 16'h0000) ? 16'h0000 : unitCycles - 16'h0001;
  assign unitTick = running_q && (divCnt_q == divLast);
  assign done = unitTick && (unitsLeft_q == 8'h01);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      divCnt_q <= 16'h0000;
    end else if (start || unitTick) begin
      divCnt_q <= 16'h0000;
    end else if (running_q) begin
      divCnt_q <= divCnt_q + 16'h0001;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      unitsLeft_q <= 8'h00;
      running_q <= 1'b0;
    end else if (start) begin
      unitsLeft_q <= 8'h01 << delayCode; // R12
      running_q <= 1'b1;
    end else if (stop || done) begin
      running_q <= 1'b0;
    end else if (unitTick) begin
      unitsLeft_q <= unitsLeft_q - 8'h01;
    end
  end
endmodule

// file: design/ilf_top.sv
// input voltage limits and under-voltage fault response
//
// Summary of operation
// R1 - The high input warning threshold is a 16-bit register the host writes and reads back.
// R2 - The low input warning threshold serves both as low warning level and as ratio regulation threshold.
// R3 - The ratio regulation threshold only acts while the special-options enable is set.
// R4 - An input below the 16-bit low fault threshold is the fault that the action byte handles.
// R5 - Response 00 keeps the output running through the fault.
// R6 - Response 01 runs on for the delay and then applies the retry field if the fault remains.
// R7 - Response 10 disables the output at once and then applies the retry field.
// R8 - Response 11 holds the output off while the fault lasts and re-enables it after.
// R9 - Retry field 000 makes no restart and keeps the output off until the fault is cleared.
// R10 - Retry codes 1 to 6 allow that many restarts, after which the output stays off until cleared.
// R11 - Retry code 7 retries without limit until commanded off or another fault shuts down.
// R12 - The delay field gives two to the power of its value in time units, 1 to 128.
// R13 - The decoded delay is both the run-on time and the restart interval, scaled by the unit length.
// R14 - Crossing either warning threshold raises a status flag and never changes the output.
// R15 - Restart attempts start one delay apart and are counted against the retry field.
`timescale 1ns/100ps
`include "ilf_regs.svh"
module ilf_top (
  input wire logic core_clk, // 20 MHz device clock
  input wire logic rst_b, // async reset, active low
  input wire ilf_pkg::ilf_cmd_t cmd, // command-register access from the bus engine
  output logic [15:0] rdData, // read data, valid with rdValid
  output logic rdValid, // read answer pulse
  output logic cmdUnknown, // pulse: access to an unhandled code
  input wire logic [15:0] vinSample, // input voltage reading, same scale as thresholds
  input wire logic vinValid, // new reading strobe
  input wire logic ratioRegEnable, // special-options enable for ratio regulation
  input wire logic [15:0] delayUnitCycles, // length of one delay time unit in clocks
  input wire logic ctrlOffPin, // asynchronous control pin, high commands off
  input wire logic operationOff, // operation command off, same clock
  input wire logic otherFault, // another fault has shut the unit down
  output logic outEnable, // output stage enable
  output logic ratioRegActive, // input below ratio regulation threshold
  output ilf_pkg::ilf_status_t status // live status flags
);
  logic [15:0] highWarn_q;
  logic [15:0] lowWarn_q;
  logic [15:0] lowFault_q;
  ilf_pkg::ilf_action_t action_q;
  ilf_pkg::ilf_state_t state_q;
  logic [2:0] attempts_q;
  logic ctrlMeta_q;
  logic ctrlSync_q;
  logic uvFault_q;
  logic highWarnFlag_q;
  logic lowWarnFlag_q;
  logic ratioReg_q;
  logic offReq;
  logic timerStart;
  logic timerStop;
  logic timerDone;
  logic retryEntry;
  logic known;

  assign known = (cmd.code == `ILF_CODE_HIGH_WARN) || (cmd.code == `ILF_CODE_LOW_WARN) ||
                 (cmd.code == `ILF_CODE_LOW_FAULT) || (cmd.code == `ILF_CODE_FAULT_ACTION);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      highWarn_q <= `ILF_RST_HIGH_WARN;
      lowWarn_q <= `ILF_RST_LOW_WARN;
      lowFault_q <= `ILF_RST_LOW_FAULT;
      action_q <= `ILF_RST_FAULT_ACTION;
    end else if (cmd.wr) begin
      unique case (cmd.code)
        `ILF_CODE_HIGH_WARN: highWarn_q <= cmd.data; // R1
        `ILF_CODE_LOW_WARN: lowWarn_q <= cmd.data; // R2
        `ILF_CODE_LOW_FAULT: lowFault_q <= cmd.data; // R4
        `ILF_CODE_FAULT_ACTION: action_q <= cmd.data[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdData <= 16'h0000;
      rdValid <= 1'b0;
      cmdUnknown <= 1'b0;
    end else begin
      rdValid <= cmd.rd && known;
      cmdUnknown <= (cmd.rd || cmd.wr) && !known;
      if (cmd.rd) begin
        unique case (cmd.code)
          `ILF_CODE_HIGH_WARN: rdData <= highWarn_q; // R1
          `ILF_CODE_LOW_WARN: rdData <= lowWarn_q;
          `ILF_CODE_LOW_FAULT: rdData <= lowFault_q;
          `ILF_CODE_FAULT_ACTION: rdData <= {8'h00, action_q};
          default: rdData <= 16'h0000;
        endcase
      end
    end
  end

  // pin comes from outside the clock domain
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrlMeta_q <= 1'b0;
      ctrlSync_q <= 1'b0;
    end else begin
      ctrlMeta_q <= ctrlOffPin;
      ctrlSync_q <= ctrlMeta_q;
    end
  end
  assign offReq = ctrlSync_q || operationOff;

  // comparisons are registered per sample so the flags hold between readings
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      uvFault_q <= 1'b0;
      highWarnFlag_q <= 1'b0;
      lowWarnFlag_q <= 1'b0;
      ratioReg_q <= 1'b0;
    end else if (vinValid) begin
      uvFault_q <= vinSample < lowFault_q; // R4
      highWarnFlag_q <= vinSample > highWarn_q; // R14
      lowWarnFlag_q <= vinSample < lowWarn_q; // R14
      ratioReg_q <= ratioRegEnable && (vinSample < lowWarn_q); // R2 R3
    end
  end
  assign ratioRegActive = ratioReg_q && ratioRegEnable; // R3

  // entering retry handling after a disable: no retries means latch off
  assign retryEntry = (state_q == ilf_pkg::ST_RUN && uvFault_q && action_q.resp == ilf_pkg::RESP_DISABLE_RETRY) ||
                      (state_q == ilf_pkg::ST_DELAY && uvFault_q && timerDone);
  assign timerStart = (state_q == ilf_pkg::ST_RUN && uvFault_q && action_q.resp == ilf_pkg::RESP_DELAY_RETRY) ||
                      (retryEntry && action_q.retries != `ILF_RETRY_NONE) ||
                      (state_q == ilf_pkg::ST_RETRY && timerDone && uvFault_q); // R13 R15
  assign timerStop = (state_q != ilf_pkg::ST_DELAY) && (state_q != ilf_pkg::ST_RETRY);

  ilf_delay_timer u_timer (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .start(timerStart),
    .stop(timerStop),
    .delayCode(action_q.delayCode),
    .unitCycles(delayUnitCycles),
    .done(timerDone)
  );

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ilf_pkg::ST_RUN;
    end else begin
      unique case (state_q)
        ilf_pkg::ST_RUN: begin
          if (uvFault_q) begin
            unique case (action_q.resp)
              ilf_pkg::RESP_IGNORE: state_q <= ilf_pkg::ST_RUN; // R5
              ilf_pkg::RESP_DELAY_RETRY: state_q <= ilf_pkg::ST_DELAY; // R6
              ilf_pkg::RESP_DISABLE_RETRY: begin
                state_q <= (action_q.retries == `ILF_RETRY_NONE) ? ilf_pkg::ST_LATCH : ilf_pkg::ST_RETRY; // R7 R9
              end
              ilf_pkg::RESP_DISABLE_RESUME: state_q <= ilf_pkg::ST_HOLD; // R8
            endcase
          end
        end
        ilf_pkg::ST_DELAY: begin
          if (!uvFault_q) begin
            state_q <= ilf_pkg::ST_RUN;
          end else if (timerDone) begin
            state_q <= (action_q.retries == `ILF_RETRY_NONE) ? ilf_pkg::ST_LATCH : ilf_pkg::ST_RETRY; // R6 R9
          end
        end
        ilf_pkg::ST_RETRY: begin
          if (otherFault) begin
            state_q <= ilf_pkg::ST_LATCH; // R11
          end else if (offReq) begin
            state_q <= ilf_pkg::ST_RUN; // R11
          end else if (timerDone) begin
            if (!uvFault_q) begin
              state_q <= ilf_pkg::ST_RUN;
            end else if (action_q.retries != `ILF_RETRY_FOREVER && attempts_q + 3'h1 >= action_q.retries) begin
              state_q <= ilf_pkg::ST_LATCH; // R10
            end
          end
        end
        // cleared by commanding the unit off once the input is good again
        ilf_pkg::ST_LATCH: begin
          if (offReq && !uvFault_q) begin
            state_q <= ilf_pkg::ST_RUN; // R9 R10
          end
        end
        ilf_pkg::ST_HOLD: begin
          if (!uvFault_q) begin
            state_q <= ilf_pkg::ST_RUN; // R8
          end
        end
        default: state_q <= ilf_pkg::ST_LATCH;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      attempts_q <= 3'h0;
    end else if (retryEntry) begin
      attempts_q <= 3'h0;
    end else if (state_q == ilf_pkg::ST_RETRY && timerDone && attempts_q != 3'h7) begin
      attempts_q <= attempts_q + 3'h1; // R15
    end
  end

  // warnings never enter here, so they cannot touch the output
  assign outEnable = ((state_q == ilf_pkg::ST_RUN) || (state_q == ilf_pkg::ST_DELAY)) && !offReq; // R5 R14
  assign status = '{highWarn: highWarnFlag_q, lowWarn: lowWarnFlag_q, lowFault: uvFault_q,
                    latchedOff: state_q == ilf_pkg::ST_LATCH};

  property p_rdback;
    @(posedge core_clk) disable iff (!rst_b)
      cmd.wr && cmd.code == `ILF_CODE_HIGH_WARN |=> highWarn_q == $past(cmd.data);
  endproperty
  a_rdback: assert property (p_rdback) else $error("high warning write lost"); // R1

  property p_ratio;
    @(posedge core_clk) disable iff (!rst_b) ratioRegActive |-> ratioRegEnable && lowWarnFlag_q;
  endproperty
  a_ratio: assert property (p_ratio) else $error("ratio regulation active without enable"); // R3

  property p_ignore;
    @(posedge core_clk) disable iff (!rst_b)
      state_q == ilf_pkg::ST_RUN && action_q.resp == ilf_pkg::RESP_IGNORE && !offReq
      |-> outEnable ##1 state_q == ilf_pkg::ST_RUN;
  endproperty
  a_ignore: assert property (p_ignore) else $error("ignored fault interrupted output"); // R5

  property p_disable;
    @(posedge core_clk) disable iff (!rst_b)
      state_q == ilf_pkg::ST_RUN && uvFault_q && action_q.resp == ilf_pkg::RESP_DISABLE_RETRY |=> !outEnable;
  endproperty
  a_disable: assert property (p_disable) else $error("output not disabled on fault"); // R7

  property p_resume;
    @(posedge core_clk) disable iff (!rst_b)
      state_q == ilf_pkg::ST_HOLD && !uvFault_q && !offReq |=> outEnable;
  endproperty
  a_resume: assert property (p_resume) else $error("output not resumed after fault"); // R8

  property p_noretry;
    @(posedge core_clk) disable iff (!rst_b)
      retryEntry && action_q.retries == `ILF_RETRY_NONE |=> state_q == ilf_pkg::ST_LATCH;
  endproperty
  a_noretry: assert property (p_noretry) else $error("restart attempted with retries off"); // R9

  property p_limit;
    @(posedge core_clk) disable iff (!rst_b)
      state_q == ilf_pkg::ST_RETRY && timerDone && uvFault_q && !offReq && !otherFault &&
      action_q.retries != `ILF_RETRY_FOREVER && attempts_q + 3'h1 == action_q.retries |=> state_q == ilf_pkg::ST_LATCH;
  endproperty
  a_limit: assert property (p_limit) else $error("retry count exceeded"); // R10

  property p_forever;
    @(posedge core_clk) disable iff (!rst_b)
      state_q == ilf_pkg::ST_RETRY && action_q.retries == `ILF_RETRY_FOREVER && !offReq && !otherFault
      |=> state_q == ilf_pkg::ST_RETRY || state_q == ilf_pkg::ST_RUN;
  endproperty
  a_forever: assert property (p_forever) else $error("continuous retry stopped"); // R11

  // cycles since the last timer start, so the span is checked end to end
  logic [23:0] spanCnt_q;
  logic [15:0] unitLen;
  logic [23:0] spanLen;

  assign unitLen = (delayUnitCycles == 16'h0000) ? 16'h0001 : delayUnitCycles;
  assign spanLen = (24'h000001 << action_q.delayCode) * {8'h00, unitLen};

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      spanCnt_q <= 24'h000000;
    end else if (timerStart) begin
      spanCnt_q <= 24'h000000;
    end else if (spanCnt_q != 24'hffffff) begin
      spanCnt_q <= spanCnt_q + 24'h000001;
    end
  end

  // assumes the unit length and action byte stay put while a delay runs
  property p_spacing;
    @(posedge core_clk) disable iff (!rst_b)
      timerDone && (state_q == ilf_pkg::ST_RETRY || state_q == ilf_pkg::ST_DELAY)
      |-> spanCnt_q == spanLen - 24'h000001;
  endproperty
  a_spacing: assert property (p_spacing) else $error("restart attempts not spaced by the delay"); // R15
endmodule

// file: testbench/ilf_host.sv
// host model: issues command-register reads and writes
`timescale 1ns/100ps
module ilf_host (
  input wire logic core_clk, // device clock
  output ilf_pkg::ilf_cmd_t cmd // command strobes to the device
);
  initial cmd = '0;
  // one-cycle strobe launched off the falling edge; idle fields scrambled so stale data never matches
  task automatic access(input logic w, input logic [7:0] c, input logic [15:0] d);
    @(negedge core_clk);
    cmd <= '{wr: w, rd: !w, code: c, data: d};
    @(negedge core_clk);
    cmd <= '{wr: 1'b0, rd: 1'b0, code: ~c, data: ~d};
  endtask
endmodule

// file: testbench/testbench.sv
// self-checking bench of the input-limit fault response block
`timescale 1ns/100ps
`include "ilf_regs.svh"
module testbench;
  int U = 2;
  localparam logic [15:0] GOOD = 16'h4000;
  localparam logic [15:0] BAD = 16'h0800;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  ilf_pkg::ilf_cmd_t cmd;
  ilf_pkg::ilf_status_t status;
  logic [15:0] rdData;
  logic [15:0] vinSample = GOOD;
  logic rdValid, cmdUnknown, outEnable, ratioRegActive;
  logic vinValid = 1'b0;
  logic ratioRegEnable = 1'b0;
  logic ctrlOffPin = 1'b0;
  logic operationOff = 1'b0;
  logic otherFault = 1'b0;
  int err_total = 0;
  int check_count = 0;
  int n;

  ilf_host i_ilf_host (.core_clk(core_clk), .cmd(cmd));
  ilf_top i_ilf_top (.core_clk(core_clk), .rst_b(rst_b), .cmd(cmd), .rdData(rdData), .rdValid(rdValid),
    .cmdUnknown(cmdUnknown), .vinSample(vinSample), .vinValid(vinValid), .ratioRegEnable(ratioRegEnable),
    .delayUnitCycles(16'(U)), .ctrlOffPin(ctrlOffPin), .operationOff(operationOff),
    .otherFault(otherFault), .outEnable(outEnable), .ratioRegActive(ratioRegActive), .status(status));

  always #25 core_clk = ~core_clk;

  task automatic conclude();
    if (err_total == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic rdChk(input logic [7:0] c, input logic [15:0] exp);
    i_ilf_host.access(1'b0, c, 16'h0000);
    chk("rdValid", rdValid, 1'b1);
    chk("rdData", rdData, exp);
  endtask

  task automatic setAct(input logic [7:0] a);
    i_ilf_host.access(1'b1, `ILF_CODE_FAULT_ACTION, {8'h00, a});
  endtask

  task automatic setVin(input logic [15:0] v);
    @(negedge core_clk);
    vinSample = v;
    vinValid = 1'b1;
    @(negedge core_clk);
    vinValid = 1'b0;
    vinSample = ~v;
  endtask

  // sel 0 watches the output enable, sel 1 the latched-off flag
  task automatic waitCond(input bit sel, input logic lvl, input int max, output int cnt);
    cnt = 0;
    while ((sel ? status.latchedOff : outEnable) !== lvl && cnt < max) begin
      @(negedge core_clk);
      cnt++;
    end
    if ((sel ? status.latchedOff : outEnable) !== lvl) begin
      err_total++;
      $display("Error wait expected %h seen timeout", lvl);
      conclude();
    end
  endtask

  // commanded off while the input is good clears a latched fault
  task automatic clear(input bit pin);
    setVin(GOOD);
    if (pin) ctrlOffPin = 1'b1;
    else operationOff = 1'b1;
    repeat (4) @(negedge core_clk);
    ctrlOffPin = 1'b0;
    operationOff = 1'b0;
    repeat (4) @(negedge core_clk);
    chk("outEnable", outEnable, 1'b1);
    chk("latchedOff", status.latchedOff, 1'b0);
  endtask

  task automatic tRegs();
    rdChk(`ILF_CODE_HIGH_WARN, `ILF_RST_HIGH_WARN);
    rdChk(`ILF_CODE_FAULT_ACTION, {8'h00, `ILF_RST_FAULT_ACTION});
    i_ilf_host.access(1'b1, `ILF_CODE_HIGH_WARN, 16'h6000);
    i_ilf_host.access(1'b1, `ILF_CODE_LOW_WARN, 16'h2000);
    i_ilf_host.access(1'b1, `ILF_CODE_LOW_FAULT, 16'h1000);
    i_ilf_host.access(1'b1, `ILF_CODE_FAULT_ACTION, 16'hff5a);
    rdChk(`ILF_CODE_HIGH_WARN, 16'h6000);
    rdChk(`ILF_CODE_LOW_WARN, 16'h2000);
    rdChk(`ILF_CODE_LOW_FAULT, 16'h1000);
    rdChk(`ILF_CODE_FAULT_ACTION, 16'h005a);
    i_ilf_host.access(1'b0, 8'h5b, 16'h0000);
    chk("cmdUnknown", cmdUnknown, 1'b1);
    chk("rdData unknown", rdData, 16'h0000);
  endtask

  task automatic tWarn();
    setAct(8'h00);
    setVin(16'h7000);
    chk("highWarn", status.highWarn, 1'b1);
    chk("outEnable", outEnable, 1'b1);
    setVin(16'h1800);
    chk("lowWarn", status.lowWarn, 1'b1);
    chk("ratioRegActive off", ratioRegActive, 1'b0);
    ratioRegEnable = 1'b1;
    setVin(16'h1800);
    chk("ratioRegActive on", ratioRegActive, 1'b1);
    ratioRegEnable = 1'b0;
    #1;
    chk("ratioRegActive disabled", ratioRegActive, 1'b0);
    setVin(BAD);
    repeat (4) @(negedge core_clk);
    chk("lowFault", status.lowFault, 1'b1);
    chk("outEnable ignore", outEnable, 1'b1);
    setVin(GOOD);
  endtask

  // disable-and-retry: time from disable to latch is retries times the decoded delay
  task automatic tRetry(input logic [2:0] r, input logic [2:0] d);
    int exp;
    exp = int'(r) * (1 << d) * U;
    setAct({2'b10, r, d});
    setVin(BAD);
    waitCond(1'b0, 1'b0, 6, n);
    waitCond(1'b1, 1'b1, 2000, n);
    chk("retry span ok", (n >= exp && n <= exp + 4), 1'b1);
    chk("outEnable latched", outEnable, 1'b0);
    clear(d[0]);
  endtask

  task automatic tModes();
    setAct({2'b01, 3'd0, 3'd2});
    setVin(BAD);
    waitCond(1'b0, 1'b0, 40, n);
    chk("run-on span ok", (n >= 4 * U && n <= 4 * U + 5), 1'b1);
    waitCond(1'b1, 1'b1, 8, n);
    clear(1'b0);
    setAct(8'hc0);
    setVin(BAD);
    waitCond(1'b0, 1'b0, 6, n);
    setVin(GOOD);
    waitCond(1'b0, 1'b1, 6, n);
    setAct({2'b10, 3'd3, 3'd1});
    setVin(BAD);
    waitCond(1'b0, 1'b0, 6, n);
    setVin(GOOD);
    waitCond(1'b0, 1'b1, 2 * U + 6, n);
    chk("latchedOff recover", status.latchedOff, 1'b0);
    setAct({2'b10, 3'd7, 3'd0});
    setVin(BAD);
    repeat (60) @(negedge core_clk);
    chk("latchedOff forever", status.latchedOff, 1'b0);
    otherFault = 1'b1;
    waitCond(1'b1, 1'b1, 6, n);
    otherFault = 1'b0;
    clear(1'b1);
  endtask

  initial begin
    repeat (2) @(negedge core_clk);
    rst_b = 1'b1;
    tRegs();
    tWarn();
    for (int r = 0; r < 7; r++) tRetry(3'(r), 3'd1);
    for (int d = 0; d < 8; d++) tRetry(3'd1, 3'(d));
    U = 3;
    tRetry(3'd2, 3'd2);
    U = 2;
    tModes();
    conclude();
  end
endmodule
